/* pwr_seq_pkg.sv */
// shared constants and types of the power mode and reset sequencer
package pwr_seq_pkg;

    // ------------
    // clock and timing
    // ------------
    localparam int CLK_PERIOD_NS = 10;
    // power-up times in ns; each divides into whole cycles
    localparam int PWRUP_T0_CYC = 140000 / CLK_PERIOD_NS;
    localparam int PWRUP_T1_CYC = 4500000 / CLK_PERIOD_NS;
    localparam int PWRUP_T2_CYC = 18000000 / CLK_PERIOD_NS;
    localparam int PWRUP_T3_CYC = 72000000 / CLK_PERIOD_NS;
    localparam int PWRUP_T4_CYC = 288000000 / CLK_PERIOD_NS;
    localparam int OST_SHORT_CYC = 1;
    localparam int OST_LONG_CYC = 16;
    localparam int SETTLE_XTAL_CYC = 512;
    localparam int SETTLE_RC_CYC = 16;
    localparam int CNT_W = 32;

    // power-up select codes
    localparam logic [2:0] PWRUP_SEL_T0 = 3'h0;
    localparam logic [2:0] PWRUP_SEL_T1 = 3'h1;
    localparam logic [2:0] PWRUP_SEL_T2 = 3'h2;
    localparam logic [2:0] PWRUP_SEL_T3 = 3'h3;

    // instruction clock divider last counts
    localparam logic [1:0] INSTR_DIV2_LAST = 2'h1;
    localparam logic [1:0] INSTR_DIV4_LAST = 2'h3;

    // ------------
    // registers
    // ------------
    localparam int PADDR_W = 12;
    localparam logic [11:0] ADDR_OSC_CTRL = 12'h000;
    localparam logic [11:0] ADDR_STATUS = 12'h004;
    localparam int OSC_FAST_SEL_BIT = 0;
    localparam int OSC_FAST_STOP_BIT = 1;
    localparam int OSC_MODE_LSB = 2;
    localparam int OSC_MODE_MSB = 3;
    localparam logic [3:0] OSC_CTRL_RESET = 4'h1;
    localparam int STAT_PD_BIT = 3;
    localparam int STAT_TO_BIT = 4;
    localparam int STAT_STATE_LSB = 8;
    localparam int STAT_GIE_BIT = 16;
    localparam logic [1:0] MODE_RUN = 2'h0;
    localparam logic [1:0] MODE_HALT = 2'h1;
    localparam logic [1:0] MODE_STANDBY = 2'h2;
    localparam logic [10:0] IRQ_VECTOR = 11'h008;
    localparam int NUM_TIMERS = 4;

    // ------------
    // sequencer states
    // ------------
    typedef enum logic [6:0] {
        ST_RESET = 7'b0000001,
        ST_PWRUP = 7'b0000010,
        ST_OST = 7'b0000100,
        ST_RUN = 7'b0001000,
        ST_STANDBY = 7'b0010000,
        ST_HALT = 7'b0100000,
        ST_SETTLE = 7'b1000000
    } seq_state_t;

endpackage : pwr_seq_pkg

/* delay_if.sv */
// carrier between the sequencer and its delay counter
`timescale 1ns/1ns
interface delay_if;
    logic load;
    logic [31:0] value;
    logic done;
    modport ctrl (output load, output value, input done);
    modport cnt (input load, input value, output done);
endinterface : delay_if

/* delay_counter.sv */
// down counter for power-up, start-up and wake settle delays
`timescale 1ns/1ns
module delay_counter (
    input wire logic MCLK,
    input wire logic RST_N,
    delay_if.cnt dly
);
    import pwr_seq_pkg::*;

    logic [CNT_W-1:0] count;

    // ------------
    // count down; done pulses the cycle after the last decrement
    // ------------
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            count <= '0;
        end else if (dly.load) begin
            count <= dly.value;
        end else if (count != '0) begin
            count <= count - 1'b1;
        end
    end

    // a fresh load cancels a pending done
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            dly.done <= 1'b0;
        end else begin
            dly.done <= !dly.load && (count == {{(CNT_W-1){1'b0}}, 1'b1});
        end
    end
endmodule : delay_counter

/* power_mode_and_reset_sequencer.sv */
// power mode and reset sequencer with apb control registers
//
// Function
// - clearing fast select moves the system clock to slow oscillator, fast keeps running
// - fast stop bit set disables fast oscillator in slow run and standby; standby with fast select set keeps it running
// - setting fast select in slow run returns to fast run
// - mode field 10b enters standby; execution stops, slow oscillator runs
// - standby stops peripherals but enabled timers keep counting
// - standby wakes on timer, watchdog, port, external, voltage, comparator, converter, touch
// - after wake, fast select picks fast run or slow run
// - halt entered by sleep instruction or mode field 01b
// - halt entry clears powerdown flag, sets timeout flag, clears watchdog
// - halt stops both oscillators, peripherals, timers and execution
// - halt wakes only on watchdog, port change, external or touch events
// - halt wake waits 512 cycles with crystal mode, else 16
// - standby wake needs no settle delay
// - wake branches to vector 0x008 if interrupts enabled, else next instruction
// - reset starts on power-on, low voltage, external pin low or watchdog
// - reset loads defined initial values, leaves unknown ones unchanged
// - power-on and low voltage set both flags; pin reset sets both only from halt
// - watchdog reset clears timeout, powerdown too from halt; sleep 1/0, clear 1/1
// - after reset release wait selected power-up time of five choices
// - then wait 1 cycle start-up for shortest setting, 16 cycles otherwise
// - after reset the startup clock bit selects fast or slow run
// - fast select at bit 0, mode field at bits 3 to 2
// - instruction clock is system clock divided by 2 or 4
//
// The implementer's own choices: the APB slave port and the placing of the registers.
`timescale 1ns/1ns
module power_mode_and_reset_sequencer #(
    parameter int unsigned PWRUP_CYC_0 = pwr_seq_pkg::PWRUP_T0_CYC,
    parameter int unsigned PWRUP_CYC_1 = pwr_seq_pkg::PWRUP_T1_CYC,
    parameter int unsigned PWRUP_CYC_2 = pwr_seq_pkg::PWRUP_T2_CYC,
    parameter int unsigned PWRUP_CYC_3 = pwr_seq_pkg::PWRUP_T3_CYC,
    parameter int unsigned PWRUP_CYC_4 = pwr_seq_pkg::PWRUP_T4_CYC
) (
    input wire logic MCLK,
    input wire logic RST_N,
    // apb slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [pwr_seq_pkg::PADDR_W-1:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // reset sources
    input wire logic POWER_ON_DETECT,
    input wire logic LOW_VOLTAGE_RESET,
    input wire logic EXT_RESET_PIN_N,
    input wire logic WATCHDOG_RESET,
    // configuration words
    input wire logic [2:0] PWRUP_SELECT,
    input wire logic STARTUP_FAST,
    input wire logic INSTR_DIV4,
    input wire logic FAST_CRYSTAL_MODE,
    input wire logic MID_CRYSTAL_MODE,
    input wire logic SLOW_CRYSTAL_MODE,
    // cpu events
    input wire logic SLEEP_INSTR,
    input wire logic WATCHDOG_CLEAR_INSTR,
    input wire logic IRQ_ENABLE_INSTR,
    input wire logic IRQ_DISABLE_INSTR,
    // wake sources
    input wire logic [pwr_seq_pkg::NUM_TIMERS-1:0] TIMER_RUN_ENABLE,
    input wire logic [pwr_seq_pkg::NUM_TIMERS-1:0] TIMER_EXPIRE,
    input wire logic WATCHDOG_TIMEOUT,
    input wire logic PORT_CHANGE,
    input wire logic EXT_INTERRUPT,
    input wire logic LOW_VOLTAGE_DETECT,
    input wire logic COMPARATOR_CHANGE,
    input wire logic CONVERT_DONE,
    input wire logic TOUCH_COMPARE,
    input wire logic TOUCH_OVERFLOW,
    // controls
    output logic FAST_OSC_EN,
    output logic SLOW_OSC_EN,
    output logic SYS_CLK_FAST,
    output logic INSTR_CLK,
    output logic CPU_RUN,
    output logic CPU_RESET,
    output logic PERIPH_EN,
    output logic [pwr_seq_pkg::NUM_TIMERS-1:0] TIMER_EN,
    output logic WATCHDOG_CLEAR,
    output logic WAKE_BRANCH,
    output logic WAKE_RESUME,
    output logic [10:0] WAKE_VECTOR
);
    import pwr_seq_pkg::*;

    seq_state_t state, next_state;
    logic [3:0] osc_control_reg;
    logic [1:0] power_mode_field, div_cnt, div_last;
    logic sys_clk_fast_select, fast_osc_stop, powerdown_flag_n, timeout_flag_n, irq_on, irq_on_at_entry;
    logic reset_event, standby_wake, halt_wake, crystal_mode, enter_halt, wake_done, apb_setup, apb_write_osc;
    logic [CNT_W-1:0] pwrup_cycles;
    logic [31:0] status_word;

    delay_if dly ();

    delay_counter u_delay (.MCLK (MCLK), .RST_N (RST_N), .dly (dly));

    // ------------
    // event decode
    // ------------
    assign sys_clk_fast_select = osc_control_reg[OSC_FAST_SEL_BIT];
    assign fast_osc_stop = osc_control_reg[OSC_FAST_STOP_BIT];
    assign power_mode_field = osc_control_reg[OSC_MODE_MSB:OSC_MODE_LSB];
    // any reset source; the pin is active low
    assign reset_event = POWER_ON_DETECT || LOW_VOLTAGE_RESET || !EXT_RESET_PIN_N || WATCHDOG_RESET;
    // a timer only wakes the core while its enable keeps it counting
    assign standby_wake = |(TIMER_EXPIRE & TIMER_RUN_ENABLE) || WATCHDOG_TIMEOUT || PORT_CHANGE
        || EXT_INTERRUPT || LOW_VOLTAGE_DETECT || COMPARATOR_CHANGE || CONVERT_DONE
        || TOUCH_COMPARE || TOUCH_OVERFLOW;
    // pure level decode, no oscillator needed to see these
    assign halt_wake = WATCHDOG_TIMEOUT || PORT_CHANGE || EXT_INTERRUPT
        || TOUCH_COMPARE || TOUCH_OVERFLOW;
    assign crystal_mode = FAST_CRYSTAL_MODE || MID_CRYSTAL_MODE || SLOW_CRYSTAL_MODE;
    assign enter_halt = (state == ST_RUN) && (next_state == ST_HALT);
    assign wake_done = (next_state == ST_RUN) && ((state == ST_STANDBY) || (state == ST_SETTLE));

    // power-up length from the three select bits; codes above 3 give the longest
    assign pwrup_cycles = (PWRUP_SELECT == PWRUP_SEL_T0) ? CNT_W'(PWRUP_CYC_0)
        : (PWRUP_SELECT == PWRUP_SEL_T1) ? CNT_W'(PWRUP_CYC_1)
        : (PWRUP_SELECT == PWRUP_SEL_T2) ? CNT_W'(PWRUP_CYC_2)
        : (PWRUP_SELECT == PWRUP_SEL_T3) ? CNT_W'(PWRUP_CYC_3) : CNT_W'(PWRUP_CYC_4);

    // ------------
    // sequencer state machine
    // ------------
    always_comb begin
        next_state = state;
        dly.load = 1'b0;
        dly.value = '0;
        if (reset_event) begin
            next_state = ST_RESET;
        end else begin
            case (state)
                ST_RESET: begin
                    next_state = ST_PWRUP;
                    dly.load = 1'b1;
                    dly.value = pwrup_cycles;
                end
                ST_PWRUP: begin
                    if (dly.done) begin
                        next_state = ST_OST;
                        dly.load = 1'b1;
                        dly.value = (PWRUP_SELECT == PWRUP_SEL_T0) ? CNT_W'(OST_SHORT_CYC)
                            : CNT_W'(OST_LONG_CYC);
                    end
                end
                ST_RUN: begin
                    if (SLEEP_INSTR || (power_mode_field == MODE_HALT)) begin
                        next_state = ST_HALT;
                    end else if (power_mode_field == MODE_STANDBY) begin
                        next_state = ST_STANDBY;
                    end
                end
                ST_STANDBY: begin
                    if (standby_wake) begin
                        next_state = ST_RUN;
                    end
                end
                ST_HALT: begin
                    if (halt_wake) begin
                        next_state = ST_SETTLE;
                        dly.load = 1'b1;
                        dly.value = crystal_mode ? CNT_W'(SETTLE_XTAL_CYC) : CNT_W'(SETTLE_RC_CYC);
                    end
                end
                ST_OST, ST_SETTLE: begin
                    if (dly.done) begin
                        next_state = ST_RUN;
                    end
                end
                default: begin
                    next_state = ST_RESET;
                end
            endcase
        end
    end

    // state register
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            state <= ST_RESET;
        end else begin
            state <= next_state;
        end
    end

    // ------------
    // oscillator control register
    // ------------
    // hardware clears the mode field on wake so halt or standby is not re-entered
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            osc_control_reg <= OSC_CTRL_RESET;
        end else if (reset_event) begin
            osc_control_reg <= OSC_CTRL_RESET;
        end else if ((state == ST_OST) && dly.done) begin
            osc_control_reg[OSC_FAST_SEL_BIT] <= STARTUP_FAST;
        end else if (wake_done || ((state == ST_HALT) && halt_wake)) begin
            osc_control_reg[OSC_MODE_MSB:OSC_MODE_LSB] <= MODE_RUN;
        end else if (apb_write_osc) begin
            osc_control_reg <= PWDATA[OSC_MODE_MSB:0];
        end
    end

    // ------------
    // timeout and powerdown status flags
    // ------------
    // flags survive a reset cycle; only the causing event decides them
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            timeout_flag_n <= 1'b1;
            powerdown_flag_n <= 1'b1;
        end else if (reset_event && (state != ST_RESET)) begin
            if (POWER_ON_DETECT || LOW_VOLTAGE_RESET) begin
                timeout_flag_n <= 1'b1;
                powerdown_flag_n <= 1'b1;
            end else if (WATCHDOG_RESET) begin
                timeout_flag_n <= 1'b0;
                powerdown_flag_n <= (state != ST_HALT);
            end else if (state == ST_HALT) begin
                timeout_flag_n <= 1'b1;
                powerdown_flag_n <= 1'b1;
            end
        end else if (enter_halt) begin
            timeout_flag_n <= 1'b1;
            powerdown_flag_n <= 1'b0;
        end else if (WATCHDOG_CLEAR_INSTR && (state == ST_RUN)) begin
            timeout_flag_n <= 1'b1;
            powerdown_flag_n <= 1'b1;
        end
    end

    // ------------
    // interrupt enable tracking
    // ------------
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            irq_on <= 1'b0;
        end else if (reset_event) begin
            irq_on <= 1'b0;
        end else if (IRQ_ENABLE_INSTR) begin
            irq_on <= 1'b1;
        end else if (IRQ_DISABLE_INSTR) begin
            irq_on <= 1'b0;
        end
    end

    // captured as the core stops, so a late change cannot alter the wake path
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            irq_on_at_entry <= 1'b0;
        end else if ((state == ST_RUN) && (next_state != ST_RUN)) begin
            irq_on_at_entry <= irq_on;
        end
    end

    // wake resume strobes and vector
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            WAKE_BRANCH <= 1'b0;
            WAKE_RESUME <= 1'b0;
            WAKE_VECTOR <= '0;
        end else begin
            WAKE_BRANCH <= wake_done && irq_on_at_entry;
            WAKE_RESUME <= wake_done && !irq_on_at_entry;
            WAKE_VECTOR <= IRQ_VECTOR;
        end
    end

    // ------------
    // instruction clock enable
    // ------------
    assign div_last = INSTR_DIV4 ? INSTR_DIV4_LAST : INSTR_DIV2_LAST;

    // runs only while executing; restarts at zero after any stop
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            div_cnt <= '0;
            INSTR_CLK <= 1'b0;
        end else if (next_state != ST_RUN) begin
            div_cnt <= '0;
            INSTR_CLK <= 1'b0;
        end else begin
            div_cnt <= (div_cnt >= div_last) ? 2'h0 : div_cnt + 2'h1;
            INSTR_CLK <= (div_cnt >= div_last);
        end
    end

    // ------------
    // clock and power controls
    // ------------
    // oscillators come back as soon as halt is left, before the settle count
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            FAST_OSC_EN <= 1'b1;
            SLOW_OSC_EN <= 1'b1;
            SYS_CLK_FAST <= 1'b1;
        end else begin
            FAST_OSC_EN <= (next_state != ST_HALT) && (sys_clk_fast_select || !fast_osc_stop);
            SLOW_OSC_EN <= (next_state != ST_HALT);
            SYS_CLK_FAST <= sys_clk_fast_select;
        end
    end

    // execution and module gating
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            CPU_RUN <= 1'b0;
            CPU_RESET <= 1'b1;
            PERIPH_EN <= 1'b0;
            TIMER_EN <= '0;
            WATCHDOG_CLEAR <= 1'b0;
        end else begin
            CPU_RUN <= (next_state == ST_RUN);
            CPU_RESET <= (next_state == ST_RESET) || (next_state == ST_PWRUP) || (next_state == ST_OST);
            PERIPH_EN <= (next_state == ST_RUN);
            TIMER_EN <= ((next_state == ST_RUN) || (next_state == ST_STANDBY)) ? TIMER_RUN_ENABLE : '0;
            WATCHDOG_CLEAR <= enter_halt;
        end
    end

    // ------------
    // apb slave
    // ------------
    assign apb_setup = PSEL && !PENABLE;
    assign apb_write_osc = PSEL && PENABLE && PREADY && PWRITE && (PADDR == ADDR_OSC_CTRL);

    always_comb begin
        status_word = '0;
        status_word[STAT_PD_BIT] = powerdown_flag_n;
        status_word[STAT_TO_BIT] = timeout_flag_n;
        status_word[STAT_STATE_LSB +: 7] = state;
        status_word[STAT_GIE_BIT] = irq_on;
    end

    // zero wait: answer is prepared during setup, ready in the first access cycle
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            PREADY <= 1'b0;
            PRDATA <= '0;
            PSLVERR <= 1'b0;
        end else if (apb_setup) begin
            PREADY <= 1'b1;
            if (PADDR == ADDR_OSC_CTRL) begin
                PRDATA <= {28'h0, osc_control_reg};
                PSLVERR <= 1'b0;
            end else if (PADDR == ADDR_STATUS) begin
                PRDATA <= status_word;
                PSLVERR <= PWRITE; // status is read only
            end else begin
                PRDATA <= '0;
                PSLVERR <= 1'b1;
            end
        end else begin
            PREADY <= 1'b0;
            PSLVERR <= 1'b0;
        end
    end
endmodule : power_mode_and_reset_sequencer

/* pwr_seq_assertions.sv */
// port-level checks of the power mode and reset sequencer
`timescale 1ns/1ns
module pwr_seq_assertions (
    input wire logic MCLK,
    input wire logic RST_N,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic [pwr_seq_pkg::PADDR_W-1:0] PADDR,
    input wire logic PREADY,
    input wire logic PSLVERR,
    input wire logic [31:0] PRDATA,
    input wire logic POWER_ON_DETECT,
    input wire logic LOW_VOLTAGE_RESET,
    input wire logic EXT_RESET_PIN_N,
    input wire logic WATCHDOG_RESET,
    input wire logic SLEEP_INSTR,
    input wire logic WATCHDOG_TIMEOUT,
    input wire logic PORT_CHANGE,
    input wire logic EXT_INTERRUPT,
    input wire logic TOUCH_COMPARE,
    input wire logic TOUCH_OVERFLOW,
    input wire logic INSTR_DIV4,
    input wire logic CPU_RUN,
    input wire logic CPU_RESET,
    input wire logic FAST_OSC_EN,
    input wire logic SLOW_OSC_EN,
    input wire logic SYS_CLK_FAST,
    input wire logic [pwr_seq_pkg::NUM_TIMERS-1:0] TIMER_EN,
    input wire logic WATCHDOG_CLEAR,
    input wire logic INSTR_CLK,
    input wire logic WAKE_BRANCH,
    input wire logic [10:0] WAKE_VECTOR
);
    import pwr_seq_pkg::*;
    // ----------------------------------------
    // helpers; slow enable low only ever means halt
    // ----------------------------------------
    wire logic rs = POWER_ON_DETECT | LOW_VOLTAGE_RESET | !EXT_RESET_PIN_N | WATCHDOG_RESET;
    wire logic hw = WATCHDOG_TIMEOUT | PORT_CHANGE | EXT_INTERRUPT | TOUCH_COMPARE | TOUCH_OVERFLOW;
    default clocking @(posedge MCLK);
    endclocking
    default disable iff (!RST_N);
    // bus answer and decode
    apb_ready_a: assert property (PSEL && !PENABLE |=> PREADY ##1 !PREADY) else $error("apb answer late");
    apb_decode_a: assert property (PSEL && !PENABLE && PADDR != ADDR_OSC_CTRL && PADDR != ADDR_STATUS
        |=> PSLVERR && PRDATA == 32'h0) else $error("unmapped access accepted");
    // halt entry, hold and wake
    halt_entry_a: assert property (CPU_RUN && SLEEP_INSTR && !rs && !PSEL |=> !CPU_RUN && !FAST_OSC_EN
        && !SLOW_OSC_EN && TIMER_EN == 4'h0 && WATCHDOG_CLEAR ##1 !WATCHDOG_CLEAR) else $error("halt entry wrong");
    halt_osc_a: assert property (!SLOW_OSC_EN |-> !FAST_OSC_EN && !CPU_RUN) else $error("clock alive in halt");
    halt_hold_a: assert property (!SLOW_OSC_EN && !rs && !hw |=> !SLOW_OSC_EN) else $error("halt left");
    halt_wake_a: assert property (!SLOW_OSC_EN && PORT_CHANGE && !rs
        |=> (SLOW_OSC_EN && !CPU_RUN)[*8]) else $error("halt wake settle wrong");
    // reset and wake targets, instruction clock rate
    reset_src_a: assert property (rs ##1 rs |=> CPU_RESET && !CPU_RUN && SYS_CLK_FAST)
        else $error("reset source ignored");
    wake_vec_a: assert property (WAKE_BRANCH |-> WAKE_VECTOR == 11'h008 && CPU_RUN) else $error("bad vector");
    instr_div_a: assert property ((INSTR_CLK && CPU_RUN && !INSTR_DIV4) ##1 (CPU_RUN && !INSTR_DIV4)[*2]
        |-> INSTR_CLK && !$past(INSTR_CLK)) else $error("instruction clock not half rate");
endmodule : pwr_seq_assertions

bind power_mode_and_reset_sequencer pwr_seq_assertions u_pwr_seq_assertions (.*);

/* tb.sv */
// self-checking bench for the power mode and reset sequencer
`timescale 1ns/1ns
module tb;
    import pwr_seq_pkg::*;
    logic MCLK = 0, RST_N = 0, PSEL = 0, PENABLE = 0, PWRITE = 0, STARTUP_FAST = 1, FAST_CRYSTAL_MODE = 0;
    logic INSTR_DIV4 = 0, MID_CRYSTAL_MODE = 0, SLOW_CRYSTAL_MODE = 0, e;
    logic [2:0] PWRUP_SELECT = 3'h1;
    logic [3:0] TIMER_RUN_ENABLE = 4'h5, rs = 4'h0, TIMER_EXPIRE, TIMER_EN;
    logic [11:0] PADDR = 12'h000;
    logic [31:0] PWDATA = 32'h0, PRDATA, q;
    logic [15:0] ev = 16'h0;
    logic [10:0] WAKE_VECTOR;
    logic PREADY, PSLVERR, FAST_OSC_EN, SLOW_OSC_EN, SYS_CLK_FAST, INSTR_CLK, CPU_RUN, CPU_RESET, PERIPH_EN;
    logic WATCHDOG_CLEAR, WAKE_BRANCH, WAKE_RESUME, POWER_ON_DETECT, LOW_VOLTAGE_RESET, EXT_RESET_PIN_N;
    logic WATCHDOG_RESET, SLEEP_INSTR, WATCHDOG_CLEAR_INSTR, IRQ_ENABLE_INSTR, IRQ_DISABLE_INSTR, WATCHDOG_TIMEOUT;
    logic PORT_CHANGE, EXT_INTERRUPT, LOW_VOLTAGE_DETECT, COMPARATOR_CHANGE, CONVERT_DONE, TOUCH_COMPARE, TOUCH_OVERFLOW;
    int fails = 0, total_checks = 0, n;
    // event vector: 7:0 wake sources, 11:8 timer expiry, 15:12 cpu events
    assign {POWER_ON_DETECT, LOW_VOLTAGE_RESET, EXT_RESET_PIN_N, WATCHDOG_RESET} = {rs[0], rs[1], !rs[2], rs[3]};
    assign {IRQ_DISABLE_INSTR, IRQ_ENABLE_INSTR, WATCHDOG_CLEAR_INSTR, SLEEP_INSTR, TIMER_EXPIRE} = ev[15:8];
    assign {TOUCH_OVERFLOW, TOUCH_COMPARE, CONVERT_DONE, COMPARATOR_CHANGE, LOW_VOLTAGE_DETECT, EXT_INTERRUPT,
        PORT_CHANGE, WATCHDOG_TIMEOUT} = ev[7:0];
    // short power-up counts keep the run brief
    power_mode_and_reset_sequencer #(.PWRUP_CYC_0(20), .PWRUP_CYC_1(30), .PWRUP_CYC_2(40), .PWRUP_CYC_3(50),
        .PWRUP_CYC_4(60)) u_power_mode_and_reset_sequencer (.*);
    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task chk(input logic ok, input string m);
        total_checks++;
        if (ok !== 1'b1) begin
            fails++;
            $display("wrong value at %0t: %s", $time, m);
        end
    endtask : chk
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge MCLK);
        {PSEL, PWRITE, PADDR, PWDATA} <= {1'b1, w, a, d};
        @(posedge MCLK);
        PENABLE <= 1'b1;
        // hold the request until ready is seen at a rising edge
        do begin
            @(posedge MCLK);
            k++;
        end while (PREADY !== 1'b1 && k < 20);
        {q, e} = {PRDATA, PSLVERR};
        {PSEL, PENABLE} <= 2'b00;
        chk(k < 20, "no ready");
    endtask : apb
    task pulse(input int i);
        @(posedge MCLK);
        ev[i] <= 1'b1;
        @(posedge MCLK);
        ev[i] <= 1'b0;
        @(negedge MCLK);
    endtask : pulse
    task settle;
        repeat (2) @(posedge MCLK);
        @(negedge MCLK);
    endtask : settle
    // bounded wait for the core to run, then judge the span
    task wait_run(input int lo, input int hi);
        n = 0;
        while (CPU_RUN !== 1'b1 && n < 2000) begin
            @(negedge MCLK);
            n++;
        end
        chk(n >= lo && n <= hi, "run start time");
    endtask : wait_run
    task status(input logic [1:0] f, input logic [6:0] st);
        apb(0, ADDR_STATUS, 32'h0);
        chk(q[4:3] === f && q[14:8] === st, "status flags or state");
    endtask : status
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task t_boot;
        repeat (3) @(posedge MCLK);
        RST_N <= 1'b1;
        wait_run(47, 53);
        chk(SYS_CLK_FAST === 1'b1 && FAST_OSC_EN === 1'b1, "fast start");
        status(2'b11, 7'h08);
    endtask : t_boot
    task t_clock;
        apb(1, ADDR_OSC_CTRL, 32'h0);
        settle;
        chk(SYS_CLK_FAST === 1'b0 && FAST_OSC_EN === 1'b1, "slow run");
        apb(1, ADDR_OSC_CTRL, 32'h2);
        settle;
        chk(FAST_OSC_EN === 1'b0, "fast stop");
        apb(1, ADDR_OSC_CTRL, 32'h3);
        settle;
        chk(SYS_CLK_FAST === 1'b1 && FAST_OSC_EN === 1'b1 && CPU_RUN === 1'b1, "fast run");
        INSTR_DIV4 <= 1'b1;
        settle;
        n = 0;
        repeat (8) @(negedge MCLK) n += INSTR_CLK;
        chk(n == 2, "divide by four");
        INSTR_DIV4 <= 1'b0;
        apb(0, ADDR_OSC_CTRL, 32'h0);
        chk(q === 32'h3 && e === 1'b0, "readback");
        apb(0, 12'h008, 32'h0);
        chk(q === 32'h0 && e === 1'b1, "unmapped read");
        apb(1, ADDR_STATUS, 32'h0);
        chk(e === 1'b1, "status write");
    endtask : t_clock
    // nine standby rounds: eight wake inputs, then a masked and an enabled timer
    task t_standby;
        for (int i = 0; i < 9; i++) begin
            pulse(15 - i % 2);
            apb(1, ADDR_OSC_CTRL, 32'h9);
            settle;
            chk(CPU_RUN === 1'b0 && SLOW_OSC_EN === 1'b1 && PERIPH_EN === 1'b0 && TIMER_EN === 4'h5, "standby");
            if (i == 8) begin
                pulse(9);
                chk(CPU_RUN === 1'b0, "masked timer woke");
            end
            pulse(i == 8 ? 10 : i);
            chk(CPU_RUN === 1'b1 && WAKE_BRANCH === i[0] && WAKE_RESUME === !i[0], "standby wake");
            chk(SYS_CLK_FAST === 1'b1 && WAKE_VECTOR === IRQ_VECTOR, "wake target");
        end
    endtask : t_standby
    task t_halt;
        for (int i = 0; i < 5; i++) begin
            FAST_CRYSTAL_MODE <= (i == 1);
            if (i[0]) apb(1, ADDR_OSC_CTRL, 32'h5);
            else pulse(12);
            settle;
            chk(SLOW_OSC_EN === 1'b0 && FAST_OSC_EN === 1'b0 && TIMER_EN === 4'h0, "halt");
            status(2'b10, 7'h20);
            pulse(3);
            pulse(10);
            chk(SLOW_OSC_EN === 1'b0 && CPU_RUN === 1'b0, "halt left early");
            pulse(i < 3 ? i : i + 3);
            chk(SLOW_OSC_EN === 1'b1 && CPU_RUN === 1'b0, "settling");
            wait_run(i == 1 ? 512 : 16, i == 1 ? 515 : 19);
        end
    endtask : t_halt
    // rows: source, from halt, expected timeout and powerdown flags
    task t_resets;
        logic [4:0] t [9];
        t = '{5'b11100, 5'b10000, 5'b00011, 5'b11001, 5'b10001, 5'b01011, 5'b11100, 5'b10111, 5'b11001};
        for (int i = 0; i < 9; i++) begin
            STARTUP_FAST <= (i < 8);
            if (t[i][2]) pulse(12);
            @(posedge MCLK);
            rs[t[i][4:3]] <= 1'b1;
            @(posedge MCLK);
            @(negedge MCLK);
            chk(CPU_RESET === 1'b1 && CPU_RUN === 1'b0, "in reset");
            @(posedge MCLK);
            rs[t[i][4:3]] <= 1'b0;
            wait_run(47, 53);
            status(t[i][1:0], 7'h08);
        end
        apb(0, ADDR_OSC_CTRL, 32'h0);
        chk(q === 32'h0 && SYS_CLK_FAST === 1'b0, "slow start");
        pulse(13);
        status(2'b11, 7'h08);
    endtask : t_resets
    task give_verdict;
        $display("checks %0d, mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : give_verdict
    // clock, watchdog and main sequence
    initial begin
        forever #5 MCLK = ~MCLK;
    end
    initial begin
        #200000;
        fails++;
        give_verdict;
    end
    initial begin
        t_boot;
        t_clock;
        t_standby;
        t_halt;
        t_resets;
        give_verdict;
    end
endmodule : tb
